// file: dv/tb_wid_dispatch.sv
// Self-checking bench for the wake-up and interrupt dispatch block.
`timescale 1ns/1ps
`include "wid_defs.vh"
module tb_wid_dispatch;
    logic core_clk = 0, rst = 1, clkEn = 1, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [6:0] ops = 7'h00;
    logic [3:0] ackDelay = 4'h0;
    logic hreadyout, hresp, intAck, intReq, globalIntEn, coreRun, coreWake, oscRun;
    logic mainTimerRun, auxTimersRun, pulseWidthRun, conversionRunning, conversionStop;
    logic [7:0] intVector, lastVec;
    int errors = 0, comparisons = 0;

    wid_dispatch u_wid_dispatch (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .sleepOp(ops[3]), .idleOp(ops[4]), .globalIntEnableOp(ops[5]),
        .globalIntDisableOp(ops[6]), .intAck(intAck), .pinChange(ops[0]),
        .mainTimerOverflow(ops[1]), .conversionDone(ops[2]), .coreRun(coreRun),
        .coreWake(coreWake), .oscRun(oscRun), .mainTimerRun(mainTimerRun),
        .auxTimersRun(auxTimersRun), .pulseWidthRun(pulseWidthRun),
        .conversionRunning(conversionRunning), .conversionStop(conversionStop),
        .intReq(intReq), .intVector(intVector), .globalIntEn(globalIntEn));
    wid_core_model u_wid_core_model (.core_clk(core_clk), .rst(rst), .intReq(intReq),
        .intVector(intVector), .ackDelay(ackDelay), .intAck(intAck), .lastVec(lastVec));

    initial forever #5 core_clk = ~core_clk;

    // ----------------------------------------
    // Bus, event and check tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task pulse(input int k);
        @(posedge core_clk);
        ops <= 7'h01 << k;
        @(posedge core_clk);
        ops <= 7'h00;
        #1;
    endtask

    task tick;
        @(posedge core_clk);
        #1;
    endtask

    task doReset;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    task end_sim;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One source event after optional low-power entry (lp 3 sleep, 4 idle, 1 green).
    task run(input int src, lp, input logic we, ie, g, wk, fl, vec, input logic [7:0] v);
        int wb;
        int fb;
        logic ck;
        wb = (src == 2) ? 3 : 1;
        fb = (src == 0) ? 1 : (src == 1) ? 0 : 2;
        ck = (lp != 3) || (src == 2 && we);
        doReset;
        xfer(1'b1, `WID_OFF_WAKEUP_CTL, 32'(we) << wb);
        if (src == 2) xfer(1'b1, `WID_OFF_ADC_INT_ENABLE, 32'(ie) << 5);
        else xfer(1'b1, `WID_OFF_INT_ENABLE, 32'(ie) << (1 - src));
        xfer(1'b1, `WID_OFF_ADC_CTL, 32'h1);
        if (lp == 1) xfer(1'b1, `WID_OFF_MODE, 32'h1);
        if (g) pulse(5);
        if (lp > 2) begin
            pulse(lp);
            chk(coreRun, 1'b0);
            chk({oscRun, mainTimerRun, auxTimersRun, pulseWidthRun}, {4{ck}});
            chk({conversionRunning, conversionStop}, {!ck || lp == 4 ? 2'h1 : 2'h2} & 2'h3 ^
                (src == 2 && we && lp == 4 ? 2'h3 : 2'h0));
        end
        pulse(src);
        chk(coreWake, wk);
        tick;
        chk(intReq, vec);
        if (vec) chk(intVector, v);
        repeat (6) tick;
        chk(globalIntEn, g && !vec);
        if (vec) chk(lastVec, v);
        rchk(`WID_OFF_INT_FLAG, 32'(fl) << fb);
        chk(coreRun, lp < 3 || wk);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 32'h1c; a += 4) rchk(8'(a), 32'h0);
        chk({coreRun, oscRun, mainTimerRun, hreadyout, hresp}, 5'h1e);
        xfer(1'b1, `WID_OFF_WAKEUP_CTL, 32'ha);
        rchk(`WID_OFF_WAKEUP_CTL, 32'ha);
        xfer(1'b1, 8'h18, 32'hff);
        rchk(8'h18, 32'h0);
        xfer(1'b1, `WID_OFF_MODE, 32'h1);
        pulse(5);
        rchk(`WID_OFF_MODE, 32'h111);
        pulse(6);
        rchk(`WID_OFF_MODE, 32'h11);
        run(0, 3, 0, 0, 0, 0, 0, 0, 8'h00);
        run(0, 4, 0, 1, 1, 0, 1, 0, 8'h00);
        run(0, 3, 1, 0, 1, 1, 0, 0, 8'h00);
        run(0, 4, 1, 1, 0, 1, 1, 0, 8'h00);
        run(0, 3, 1, 1, 1, 1, 1, 1, 8'h06);
        run(0, 0, 1, 0, 0, 0, 0, 0, 8'h00);
        run(0, 1, 0, 1, 1, 0, 1, 1, 8'h06);
        ackDelay <= 4'h3;
        run(1, 3, 0, 1, 1, 0, 0, 0, 8'h00);
        run(1, 4, 0, 1, 0, 1, 1, 0, 8'h00);
        run(1, 0, 0, 1, 0, 0, 1, 0, 8'h00);
        run(1, 4, 0, 1, 1, 1, 1, 1, 8'h09);
        run(1, 1, 0, 1, 1, 0, 1, 1, 8'h09);
        run(2, 3, 0, 0, 0, 0, 0, 0, 8'h00);
        run(2, 4, 0, 1, 0, 0, 1, 0, 8'h00);
        run(2, 3, 1, 0, 0, 1, 0, 0, 8'h00);
        run(2, 4, 1, 1, 0, 1, 1, 0, 8'h00);
        run(2, 3, 1, 1, 1, 1, 1, 1, 8'h0c);
        run(2, 0, 0, 1, 1, 0, 1, 1, 8'h0c);
        run(2, 0, 0, 0, 1, 0, 0, 0, 8'h00);
        doReset;
        xfer(1'b1, `WID_OFF_INT_ENABLE, 32'h1);
        xfer(1'b1, `WID_OFF_MODE, 32'h1);
        pulse(4);
        rchk(`WID_OFF_MODE, 32'h21);
        pulse(1);
        rchk(`WID_OFF_MODE, 32'h11);
        doReset;
        xfer(1'b1, `WID_OFF_INT_ENABLE, 32'h2);
        pulse(0);
        xfer(1'b1, `WID_OFF_INT_FLAG, 32'h0);
        rchk(`WID_OFF_INT_FLAG, 32'h2);
        xfer(1'b1, `WID_OFF_INT_FLAG, 32'h2);
        rchk(`WID_OFF_INT_FLAG, 32'h0);
        // A pin change in the same cycle as the clear keeps the flag set.
        fork
            xfer(1'b1, `WID_OFF_INT_FLAG, 32'h2);
            begin
                @(posedge core_clk);
                pulse(0);
            end
        join
        rchk(`WID_OFF_INT_FLAG, 32'h2);
        xfer(1'b1, `WID_OFF_INT_FLAG, 32'h2);
        rchk(`WID_OFF_INT_FLAG, 32'h0);
        @(posedge core_clk);
        clkEn <= 1'b0;
        pulse(0);
        @(posedge core_clk);
        clkEn <= 1'b1;
        rchk(`WID_OFF_INT_FLAG, 32'h0);
        end_sim;
    end

    initial begin
        #100000;
        errors++;
        end_sim;
    end
endmodule // tb_wid_dispatch

// file: dv/wid_core_model.sv
// Behavioural processor core that takes interrupt vectors and acknowledges them.
`timescale 1ns/1ps
module wid_core_model (
    input logic core_clk,
    input logic rst,
    input logic intReq,
    input logic [7:0] intVector,
    input logic [3:0] ackDelay,
    output logic intAck = 1'b0,
    output logic [7:0] lastVec
);
    logic [3:0] waitCnt;

    // The core sees a request at least one cycle before it acknowledges it.
    always @(posedge core_clk) begin
        if (rst) begin
            waitCnt <= 4'h0;
            intAck <= 1'b0;
            lastVec <= 8'h00;
        end else begin
            intAck <= 1'b0;
            if (intReq && !intAck) begin
                if (waitCnt == ackDelay) begin
                    intAck <= 1'b1;
                    lastVec <= intVector;
                    waitCnt <= 4'h0;
                end else begin
                    waitCnt <= waitCnt + 4'h1;
                end
            end else begin
                waitCnt <= 4'h0;
            end
        end
    end
endmodule // wid_core_model

// file: dv/wid_dispatch_properties.sv
// Concurrent checks on the core-side ports of the dispatch block.
`timescale 1ns/1ps
module wid_dispatch_chk #(
    parameter VEC_W = 8
) (
    input logic core_clk,
    input logic rst,
    input logic clkEn,
    input logic sleepOp,
    input logic idleOp,
    input logic mainTimerOverflow,
    input logic intAck,
    input logic coreRun,
    input logic coreWake,
    input logic oscRun,
    input logic mainTimerRun,
    input logic conversionRunning,
    input logic conversionStop,
    input logic intReq,
    input logic [VEC_W-1:0] intVector,
    input logic globalIntEn
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Low-power entry, wake-up and vectors
    // ----------------------------------------
    sequence sIdleState;
        !coreRun && oscRun && mainTimerRun;
    endsequence
    sequence sAckDone;
        !intReq && !globalIntEn;
    endsequence

    AST_SLEEP_ENTRY: assert property (sleepOp && clkEn && coreRun |=> !coreRun)
        else $error("core still runs after sleep entry");
    AST_IDLE_ENTRY: assert property (idleOp && !sleepOp && clkEn && coreRun |=> sIdleState)
        else $error("idle entry stopped the timers or left the core running");
    AST_CLOCKS_TOGETHER: assert property (!oscRun |-> !mainTimerRun && !coreRun)
        else $error("timer runs while the oscillator is stopped");
    AST_WAKE_RUNS: assert property ($rose(coreWake) |-> $rose(coreRun))
        else $error("wake pulse without the core resuming");
    AST_WAKE_ONE_CYCLE: assert property (coreWake && clkEn |=> !coreWake)
        else $error("wake pulse longer than one cycle");
    AST_TIMER_SLEEP: assert property (mainTimerOverflow && clkEn && !oscRun |=> !coreWake)
        else $error("timer overflow woke the device from sleep");
    AST_REQ_NEEDS_GIE: assert property ($rose(intReq) |-> globalIntEn && coreRun)
        else $error("interrupt request without global enable or while halted");
    AST_VECTOR_LEGAL: assert property (intReq |-> intVector inside {8'h06, 8'h09, 8'h0c})
        else $error("interrupt vector outside the source vectors");
    AST_REQ_HOLDS: assert property (intReq && !intAck |=> intReq && $stable(intVector))
        else $error("request or vector changed before acknowledge");
    AST_ACK_CLEARS: assert property (intReq && intAck && clkEn |=> sAckDone)
        else $error("acknowledge did not clear request and global enable");
    AST_ENTRY_STOP: assert property (conversionStop && clkEn |->
        !conversionRunning && !coreRun ##1 !conversionStop)
        else $error("converter stop pulse malformed");
endmodule // wid_dispatch_chk

bind wid_dispatch wid_dispatch_chk #(.VEC_W(VEC_W)) u_wid_dispatch_chk (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .sleepOp(sleepOp), .idleOp(idleOp),
    .mainTimerOverflow(mainTimerOverflow), .intAck(intAck), .coreRun(coreRun),
    .coreWake(coreWake), .oscRun(oscRun), .mainTimerRun(mainTimerRun),
    .conversionRunning(conversionRunning), .conversionStop(conversionStop),
    .intReq(intReq), .intVector(intVector), .globalIntEn(globalIntEn)
);

// file: verilog/wid_defs.vh
// Constants for the wake-up and interrupt dispatch block.
`ifndef WID_DEFS_VH
`define WID_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WID_OFF_WAKEUP_CTL 8'h00
`define WID_OFF_INT_ENABLE 8'h04
`define WID_OFF_ADC_INT_ENABLE 8'h08
`define WID_OFF_INT_FLAG 8'h0c
`define WID_OFF_ADC_CTL 8'h10
`define WID_OFF_MODE 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WID_BIT_PIN_WAKE_EN 1
`define WID_BIT_CONV_WAKE_EN 3
`define WID_BIT_TIMER_INT_EN 0
`define WID_BIT_PIN_INT_EN 1
`define WID_BIT_CONV_INT_EN 5
`define WID_BIT_TIMER_PEND 0
`define WID_BIT_PIN_PEND 1
`define WID_BIT_CONV_PEND 2
`define WID_BIT_CONV_RUN 0
`define WID_BIT_GREEN_SEL 0
`define WID_BIT_MODE_LO 4
`define WID_BIT_MODE_HI 5
`define WID_BIT_GIE 8

// ----------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------
`define WID_RST_WAKEUP_CTL 8'h00
`define WID_RST_INT_ENABLE 8'h00
`define WID_RST_ADC_INT_ENABLE 8'h00
`define WID_VEC_PIN 8'h06
`define WID_VEC_TIMER 8'h09
`define WID_VEC_CONV 8'h0c

`endif

// file: verilog/wid_dispatch.v
// Wake-up and interrupt dispatch for pin change, main timer and conversion.
`timescale 1ns/1ps
`include "wid_defs.vh"

// Function
// - After wake-up: vector if global and source interrupt enables set, else next instruction.
// - Sleep stops oscillator, timers and pulse generator unless conversion wake armed.
// - Idle keeps main timer, aux timers and pulse generator running.
// - Pin change with wake and interrupt enables clear does nothing.
// - Pin interrupt enable only: low power change sets pending, no wake.
// - Pin wake enable only: change wakes, next instruction, no pending flag.
// - Both pin enables, global off: wake, set pending, next instruction.
// - Both pin enables, global on: wake, set pending, pin vector.
// - Run modes ignore pin wake enable; interrupt enable sets pending.
// - Timer overflow never wakes sleep; in idle with enable wakes, sets pending.
// - Timer enable, global off: overflow sets pending, next instruction.
// - Timer enable, global on: overflow sets pending, timer vector.
// - Conversion enables clear: entering low power stops converter, no wake.
// - Conversion interrupt only: entry sets pending, stops converter, no wake.
// - Conversion wake set: clocks keep running, completion wakes device.
// - Conversion enables set, global off: wake, pending, next instruction.
// - Conversion enables set, global on: wake, pending, conversion vector.
// - Run modes: conversion enable sets pending and vectors; clear raises nothing.
module wid_dispatch #(
    parameter VEC_W = 8
) (
    input wire core_clk,
    input wire rst,
    input wire clkEn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire sleepOp,
    input wire idleOp,
    input wire globalIntEnableOp,
    input wire globalIntDisableOp,
    input wire intAck,
    input wire pinChange,
    input wire mainTimerOverflow,
    input wire conversionDone,
    output reg coreRun,
    output reg coreWake,
    output reg oscRun,
    output reg mainTimerRun,
    output reg auxTimersRun,
    output reg pulseWidthRun,
    output reg conversionRunning,
    output reg conversionStop,
    output reg intReq,
    output reg [VEC_W-1:0] intVector,
    output reg globalIntEn
);

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    localparam [1:0] MODE_NORMAL = 2'b00;
    localparam [1:0] MODE_GREEN = 2'b01;
    localparam [1:0] MODE_IDLE = 2'b10;
    localparam [1:0] MODE_SLEEP = 2'b11;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg greenSel_reg;
    reg [7:0] wakeupCtl_reg;
    reg [7:0] intEnable_reg;
    reg [7:0] adcIntEnable_reg;
    reg wrPend_reg;
    reg [7:0] wrAddr_reg;
    reg [31:0] rdMux;
    reg [VEC_W-1:0] vecSel;
    wire [2:0] pendFlags;
    wire [2:0] flagSet;
    wire [2:0] flagClear;
    wire addrPhase;
    wire lowPower;
    wire runMode;
    wire pinWakeEn;
    wire convWakeEn;
    wire timerIntEn;
    wire pinIntEn;
    wire convIntEn;
    wire entryOp;
    wire entryStop;
    wire pinSet;
    wire pinWake;
    wire timerSet;
    wire timerWake;
    wire convSet;
    wire convWake;
    wire wakeNow;
    wire [2:0] active;
    wire runNext;
    wire clocksOn;

    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    assign pinWakeEn = wakeupCtl_reg[`WID_BIT_PIN_WAKE_EN];
    assign convWakeEn = wakeupCtl_reg[`WID_BIT_CONV_WAKE_EN];
    assign timerIntEn = intEnable_reg[`WID_BIT_TIMER_INT_EN];
    assign pinIntEn = intEnable_reg[`WID_BIT_PIN_INT_EN];
    assign convIntEn = adcIntEnable_reg[`WID_BIT_CONV_INT_EN];
    assign lowPower = (mode_reg == MODE_IDLE) || (mode_reg == MODE_SLEEP);
    assign runMode = !lowPower;

    // ----------------------------------------------------------------
    // Event qualification
    // ----------------------------------------------------------------
    // Low power entry; the converter is stopped unless its wake is armed.
    assign entryOp = runMode && (sleepOp || idleOp);
    assign entryStop = entryOp && !convWakeEn;

    // Pin change sets pending whenever its interrupt enable is set.
    assign pinSet = pinChange && pinIntEn;
    // Pin wake enable only matters in sleep or idle.
    assign pinWake = pinChange && pinWakeEn && lowPower;

    // The timer is frozen in sleep unless conversion wake is armed; an overflow in sleep is ignored either way.
    assign timerSet = mainTimerOverflow && timerIntEn
        && (mode_reg != MODE_SLEEP);
    assign timerWake = timerSet && (mode_reg == MODE_IDLE);

    // In low power a completion counts only while conversion wake is armed.
    assign convSet = (conversionDone && convIntEn && (runMode || convWakeEn))
        || (entryStop && convIntEn);
    assign convWake = conversionDone && convWakeEn && lowPower;

    assign wakeNow = pinWake || timerWake || convWake;

    // ----------------------------------------------------------------
    // Pending flags
    // ----------------------------------------------------------------
    assign flagSet[`WID_BIT_TIMER_PEND] = timerSet;
    assign flagSet[`WID_BIT_PIN_PEND] = pinSet;
    assign flagSet[`WID_BIT_CONV_PEND] = convSet;
    assign flagClear = (wrPend_reg && hit(wrAddr_reg, `WID_OFF_INT_FLAG))
        ? hwdata[2:0] : 3'h0;

    wid_flag_bank #(
        .N(3)
    ) uFlags (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .setIn(flagSet),
        .clearIn(flagClear),
        .flags(pendFlags)
    );

    // ----------------------------------------------------------------
    // Mode sequencing
    // ----------------------------------------------------------------
    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_NORMAL, MODE_GREEN: begin
                if (sleepOp) begin
                    mode_next = MODE_SLEEP;
                end else if (idleOp) begin
                    mode_next = MODE_IDLE;
                end else begin
                    mode_next = greenSel_reg ? MODE_GREEN : MODE_NORMAL;
                end
            end
            MODE_IDLE, MODE_SLEEP: begin
                if (wakeNow) begin
                    mode_next = greenSel_reg ? MODE_GREEN : MODE_NORMAL;
                end
            end
            default: begin
                mode_next = MODE_NORMAL;
            end
        endcase
    end

    assign runNext = (mode_next == MODE_NORMAL) || (mode_next == MODE_GREEN);
    // Sleep halts the clocks; conversion wake keeps them alive.
    assign clocksOn = (mode_next != MODE_SLEEP) || convWakeEn;

    // ----------------------------------------------------------------
    // Interrupt selection, fixed priority pin, timer, conversion
    // ----------------------------------------------------------------
    assign active[`WID_BIT_TIMER_PEND] = pendFlags[`WID_BIT_TIMER_PEND] && timerIntEn;
    assign active[`WID_BIT_PIN_PEND] = pendFlags[`WID_BIT_PIN_PEND] && pinIntEn;
    assign active[`WID_BIT_CONV_PEND] = pendFlags[`WID_BIT_CONV_PEND] && convIntEn;

    always @* begin
        if (active[`WID_BIT_PIN_PEND]) begin
            vecSel = `WID_VEC_PIN;
        end else if (active[`WID_BIT_TIMER_PEND]) begin
            vecSel = `WID_VEC_TIMER;
        end else begin
            vecSel = `WID_VEC_CONV;
        end
    end

    // ----------------------------------------------------------------
    // Mode, clocks, dispatch
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= MODE_NORMAL;
            coreRun <= 1'b1;
            coreWake <= 1'b0;
            oscRun <= 1'b1;
            mainTimerRun <= 1'b1;
            auxTimersRun <= 1'b1;
            pulseWidthRun <= 1'b1;
            conversionStop <= 1'b0;
            intReq <= 1'b0;
            intVector <= {VEC_W{1'b0}};
            globalIntEn <= 1'b0;
        end else if (clkEn) begin
            mode_reg <= mode_next;
            coreRun <= runNext;
            coreWake <= lowPower && wakeNow;
            oscRun <= clocksOn;
            mainTimerRun <= clocksOn;
            auxTimersRun <= clocksOn;
            pulseWidthRun <= clocksOn;
            conversionStop <= entryStop;
            if (intAck) begin
                intReq <= 1'b0;
                globalIntEn <= 1'b0;
            end else begin
                if (globalIntDisableOp) begin
                    globalIntEn <= 1'b0;
                end else if (globalIntEnableOp) begin
                    globalIntEn <= 1'b1;
                end
                // Without global enable the core just runs on sequentially.
                if (!intReq && runMode && globalIntEn && (|active)) begin
                    intReq <= 1'b1;
                    intVector <= vecSel;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------------------------------
    assign addrPhase = hsel && htrans[1] && hready;

    always @* begin
        rdMux = 32'h0;
        if (hit(haddr[7:0], `WID_OFF_WAKEUP_CTL)) begin
            rdMux[7:0] = wakeupCtl_reg;
        end else if (hit(haddr[7:0], `WID_OFF_INT_ENABLE)) begin
            rdMux[7:0] = intEnable_reg;
        end else if (hit(haddr[7:0], `WID_OFF_ADC_INT_ENABLE)) begin
            rdMux[7:0] = adcIntEnable_reg;
        end else if (hit(haddr[7:0], `WID_OFF_INT_FLAG)) begin
            rdMux[2:0] = pendFlags;
        end else if (hit(haddr[7:0], `WID_OFF_ADC_CTL)) begin
            rdMux[`WID_BIT_CONV_RUN] = conversionRunning;
        end else if (hit(haddr[7:0], `WID_OFF_MODE)) begin
            rdMux[`WID_BIT_GREEN_SEL] = greenSel_reg;
            rdMux[`WID_BIT_MODE_HI:`WID_BIT_MODE_LO] = mode_reg;
            rdMux[`WID_BIT_GIE] = globalIntEn;
        end
        if (haddr[31:8] != 24'h0) begin
            rdMux = 32'h0;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h0;
        end else if (clkEn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_reg <= addrPhase && hwrite && (haddr[31:8] == 24'h0);
            if (addrPhase) begin
                wrAddr_reg <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            wakeupCtl_reg <= `WID_RST_WAKEUP_CTL;
            intEnable_reg <= `WID_RST_INT_ENABLE;
            adcIntEnable_reg <= `WID_RST_ADC_INT_ENABLE;
            greenSel_reg <= 1'b0;
            conversionRunning <= 1'b0;
        end else if (clkEn) begin
            if (wrPend_reg && hit(wrAddr_reg, `WID_OFF_WAKEUP_CTL)) begin
                wakeupCtl_reg <= hwdata[7:0];
            end else if (wrPend_reg && hit(wrAddr_reg, `WID_OFF_INT_ENABLE)) begin
                intEnable_reg <= hwdata[7:0];
            end else if (wrPend_reg && hit(wrAddr_reg, `WID_OFF_ADC_INT_ENABLE)) begin
                adcIntEnable_reg <= hwdata[7:0];
            end else if (wrPend_reg && hit(wrAddr_reg, `WID_OFF_MODE)) begin
                greenSel_reg <= hwdata[`WID_BIT_GREEN_SEL];
            end
            // Hardware stop and completion win over a software start.
            if (entryStop || conversionDone) begin
                conversionRunning <= 1'b0;
            end else if (wrPend_reg && hit(wrAddr_reg, `WID_OFF_ADC_CTL)) begin
                conversionRunning <= hwdata[`WID_BIT_CONV_RUN];
            end
        end
    end

endmodule // wid_dispatch

// file: verilog/wid_flag_bank.v
// Sticky pending flags: hardware sets, software clears, set wins.
`timescale 1ns/1ps

module wid_flag_bank #(
    parameter N = 3
) (
    input wire core_clk,
    input wire rst,
    input wire clkEn,
    input wire [N-1:0] setIn,
    input wire [N-1:0] clearIn,
    output wire [N-1:0] flags
);

    reg [N-1:0] flag_reg;
    genvar i;

    // ----------------------------------------------------------------
    // One flag per source
    // ----------------------------------------------------------------
    generate
        for (i = 0; i < N; i = i + 1) begin : gFlag
            always @(posedge core_clk) begin
                if (rst) begin
                    flag_reg[i] <= 1'b0;
                end else if (clkEn) begin
                    if (setIn[i]) begin
                        flag_reg[i] <= 1'b1;
                    end else if (clearIn[i]) begin
                        flag_reg[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign flags = flag_reg;

endmodule // wid_flag_bank
